/* File: core/bbf_pkg.sv */
// shared constants, types and sample arithmetic of the baseband input front end
package bbf_pkg;
  localparam int SAMPLE_W = 18;                  // full sample width
  localparam int NCH_DEF  = 12;                  // carriers on the shared bus
  localparam int GAIN_W   = 16;                  // signed gain word
  localparam int GAIN_FRAC = 14;                 // gain fraction bits, 16'h4000 is unity
  localparam int ACC_W    = 48;                  // power accumulator width
  localparam int RES_W    = 32;                  // readable power result width
  localparam int RES_LSB  = 16;                  // accumulator bit that lands in result bit 0
  localparam int MEM_AW   = 4;                   // result memory address width

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_PILOT_GAIN = 8'h08;
  localparam logic [7:0] OFS_GAIN_BASE  = 8'h40;  // one word per carrier
  localparam logic [7:0] OFS_POWER_BASE = 8'h80;  // one word per carrier

  // control fields
  localparam int CTRL_BYPASS   = 0;
  localparam int CTRL_PILOT_EN = 1;
  localparam int CTRL_MEAS_RUN = 2;
  localparam int CTRL_LAST_LSB = 4;              // last carrier index, 4 bits
  localparam int CTRL_PCH_LSB  = 8;              // pilot carrier index, 4 bits
  // status fields
  localparam int STAT_DONE = 0;
  localparam int STAT_RUN  = 1;
  localparam int STAT_FERR = 2;

  // reset values
  localparam logic [3:0]  LAST_RST  = 4'hB;
  localparam logic [15:0] GAIN_RST  = 16'h4000;
  localparam logic [15:0] PGAIN_RST = 16'h0000;
  localparam logic [15:0] LFSR_RST  = 16'hACE1;

  // power meter sequencing
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_ACC, MEAS_COPY} bbf_meas_t;

  // clip a 20-bit intermediate back to the 18-bit sample range
  function automatic logic [17:0] bbf_sat(input logic [19:0] v);
    if (v[19:17] != {3{v[17]}}) return v[19] ? 18'h2_0000 : 18'h1_FFFF;
    return v[17:0];
  endfunction : bbf_sat

  // signed sample times signed gain, rescaled and clipped
  function automatic logic [17:0] bbf_scale(input logic [17:0] s, input logic [15:0] g);
    logic signed [33:0] p;
    p = $signed(s) * $signed(g);
    return bbf_sat(p[33:14]);
  endfunction : bbf_scale

  // saturating add of a 20-bit signed offset
  function automatic logic [17:0] bbf_add(input logic [17:0] s, input logic [19:0] o);
    logic [19:0] t;
    t = {{2{s[17]}}, s} + o;
    return bbf_sat(t);
  endfunction : bbf_add
endpackage : bbf_pkg

/* File: core/bbf_mem_if.sv */
// connection between the front end and its power result memory
`timescale 1ns/1ps
interface bbf_mem_if;
  logic                       wr_en;    // write strobe
  logic [bbf_pkg::MEM_AW-1:0] wr_addr;  // carrier written
  logic [bbf_pkg::RES_W-1:0]  wr_data;  // result written
  logic [bbf_pkg::MEM_AW-1:0] rd_addr;  // carrier read
  logic [bbf_pkg::RES_W-1:0]  rd_data;  // registered read data
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : bbf_mem_if

/* File: core/bbf_result_mem.sv */
// small memory holding the latched power result of each carrier
`timescale 1ns/1ps
module bbf_result_mem #(
  parameter int DEPTH = bbf_pkg::NCH_DEF  // number of carriers
) (
  input wire logic clk,     // register clock
  input wire logic presetn, // async reset, active low
  bbf_mem_if.mem   port     // write and read side
);
  logic [bbf_pkg::RES_W-1:0] mem_reg [DEPTH];  // result words

  if (DEPTH < 1 || DEPTH > 2 ** bbf_pkg::MEM_AW) begin : g_bad_depth
    $error("result memory depth out of range");
  end

  // write port; cleared at reset so early reads are defined
  always_ff @(posedge clk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < DEPTH; k++) mem_reg[k] <= 32'h0000_0000;
    end else if (port.wr_en && int'(port.wr_addr) < DEPTH) begin
      mem_reg[port.wr_addr] <= port.wr_data;
    end
  end

  // read data always from a register, one cycle after the address
  always_ff @(posedge clk or negedge presetn) begin
    if (!presetn) port.rd_data <= 32'h0000_0000;
    else if (int'(port.rd_addr) < DEPTH) port.rd_data <= mem_reg[port.rd_addr];
    else port.rd_data <= 32'h0000_0000;
  end
endmodule : bbf_result_mem

/* File: core/bbf_front_end.sv */
// baseband iq input front end: apb registers, channel split, gain, pilot and power meters
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module bbf_front_end #(
  parameter int NCH = bbf_pkg::NCH_DEF,  // carriers on the bus
  parameter int SW  = bbf_pkg::SAMPLE_W  // sample width
) (
  input  wire logic          pclk,                // 40 MHz clock
  input  wire logic          presetn,             // async reset, active low
  input  wire logic          psel,                // apb select
  input  wire logic          penable,             // apb access phase
  input  wire logic          pwrite,              // apb direction
  input  wire logic [7:0]    paddr,               // apb byte address
  input  wire logic [31:0]   pwdata,              // apb write data
  output logic      [31:0]   prdata,              // apb read data
  output logic               pready,              // apb ready
  output logic               pslverr,             // unmapped address
  input  wire logic [15:0]   bb_sample_bus,       // upper sample bits
  input  wire logic [1:0]    multi_function_pins, // lowest two sample bits
  input  wire logic          bb_frame_marker,     // first word of a sequence
  output logic               duc_valid,           // channel pair present
  output logic      [3:0]    duc_ch,              // upconverter channel
  output logic      [SW-1:0] duc_i,               // in-phase sample
  output logic      [SW-1:0] duc_q,               // quadrature sample
  output logic               prs_valid,           // bypass word present
  output logic               prs_iq,              // bypass word is Q
  output logic      [SW-1:0] prs_data             // bypass word
);
  localparam logic [3:0] LAST_CH = 4'(NCH - 1);  // highest carrier index
  localparam int COPY_MAX = NCH + 2;             // bound for result latching

  if (SW != 18 || NCH < 1 || NCH > 16) begin : g_bad_param
    $error("front end supports 18-bit samples and 1 to 16 carriers");
  end

  // control and state registers
  logic        ack_reg;                       // apb wait state done
  logic [31:0] prdata_reg;                    // captured read data
  logic        bypass_reg;                    // straight to peak reduction
  logic        pilot_en_reg;                  // pilot insertion on
  logic        run_reg;                       // shared meter control
  logic [3:0]  last_reg;                      // last carrier in sequence
  logic [3:0]  pch_reg;                       // carrier that carries pilot
  logic [15:0] pgain_reg;                     // pilot amplitude
  logic [15:0] gain_reg [NCH];                // per-carrier gain
  logic        ferr_reg;                      // marker seen out of place
  logic        done_reg;                      // results latched
  logic        synced_reg;                    // first marker seen
  logic [3:0]  ch_reg;                        // next word's carrier
  logic        q_reg;                         // next word is Q
  logic [17:0] i_hold_reg;                    // I waiting for its Q
  logic [15:0] lfsr_reg;                      // pilot chip generator
  logic [bbf_pkg::ACC_W-1:0] acc_reg [NCH];   // power accumulators
  logic [3:0]  walk_reg;                      // carrier being latched
  bbf_pkg::bbf_meas_t meas_state;             // meter sequencer

  bbf_mem_if mem_bus ();                      // result memory link

  bbf_result_mem #(.DEPTH(NCH)) u_mem (
    .clk     (pclk),
    .presetn (presetn),
    .port    (mem_bus)
  );

  // apb decode; one wait state so every register, memory too, reads from flops
  function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:6] == base[7:6] && int'(a[5:2]) < NCH;
  endfunction : bank_hit

  wire       acc_phase = psel & penable;                         // access phase
  wire [3:0] reg_idx   = paddr[5:2];                             // bank entry
  wire       sel_ctrl  = paddr[7:2] == bbf_pkg::OFS_CTRL[7:2];
  wire       sel_stat  = paddr[7:2] == bbf_pkg::OFS_STATUS[7:2];
  wire       sel_pg    = paddr[7:2] == bbf_pkg::OFS_PILOT_GAIN[7:2];
  wire       sel_gain  = bank_hit(paddr, bbf_pkg::OFS_GAIN_BASE);
  wire       sel_pow   = bank_hit(paddr, bbf_pkg::OFS_POWER_BASE);
  wire       mapped    = sel_ctrl | sel_stat | sel_pg | sel_gain | sel_pow;
  wire       wr_stb    = acc_phase & ack_reg & pwrite & mapped;  // write lands here
  wire [15:0] gain_rd  = sel_gain ? gain_reg[reg_idx] : 16'h0000;

  wire [31:0] ctrl_val = {20'h0_0000, pch_reg, last_reg, 1'b0, run_reg, pilot_en_reg, bypass_reg};
  wire [31:0] stat_val = {29'h0000_0000, ferr_reg, meas_state != bbf_pkg::MEAS_IDLE, done_reg};
  wire [31:0] rd_mux   = sel_ctrl ? ctrl_val :
                         sel_stat ? stat_val :
                         sel_pg   ? {16'h0000, pgain_reg} :
                         sel_gain ? {16'h0000, gain_rd} :
                         sel_pow  ? mem_bus.rd_data : 32'h0000_0000;

  assign pready  = ack_reg;
  assign pslverr = ack_reg & ~mapped;
  assign prdata  = prdata_reg;

  // wait state and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg    <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= acc_phase & ~ack_reg;
      if (acc_phase && !ack_reg && !pwrite) prdata_reg <= rd_mux;
    end
  end

  // software written controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_reg   <= 1'b0;
      pilot_en_reg <= 1'b0;
      run_reg      <= 1'b0;
      last_reg     <= bbf_pkg::LAST_RST;
      pch_reg      <= 4'h0;
      pgain_reg    <= bbf_pkg::PGAIN_RST;
      for (int k = 0; k < NCH; k++) gain_reg[k] <= bbf_pkg::GAIN_RST;
    end else if (wr_stb) begin
      if (sel_ctrl) begin
        bypass_reg   <= pwdata[bbf_pkg::CTRL_BYPASS];
        pilot_en_reg <= pwdata[bbf_pkg::CTRL_PILOT_EN];
        run_reg      <= pwdata[bbf_pkg::CTRL_MEAS_RUN];
        last_reg     <= pwdata[bbf_pkg::CTRL_LAST_LSB +: 4];
        pch_reg      <= pwdata[bbf_pkg::CTRL_PCH_LSB +: 4];
      end
      if (sel_pg) pgain_reg <= pwdata[15:0];
      if (sel_gain) gain_reg[reg_idx] <= pwdata[15:0];
    end
  end

  // word framing; a count past the carrier count is clamped to what exists
  wire [17:0] word    = {bb_sample_bus, multi_function_pins};
  wire [3:0]  last_ch = (last_reg > LAST_CH) ? LAST_CH : last_reg;
  wire [3:0]  cur_ch  = bb_frame_marker ? 4'h0 : ch_reg;
  wire        cur_q   = bb_frame_marker ? 1'b0 : q_reg;
  wire        live    = synced_reg | bb_frame_marker;                   // aligned word
  wire        misplace = bb_frame_marker & synced_reg & (q_reg | (ch_reg != 4'h0));
  wire        ferr_clr = wr_stb & sel_stat & pwdata[bbf_pkg::STAT_FERR];

  // alignment counters and the sticky misplaced-marker flag, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synced_reg <= 1'b0;
      ch_reg     <= 4'h0;
      q_reg      <= 1'b0;
      ferr_reg   <= 1'b0;
      i_hold_reg <= 18'h0_0000;
    end else begin
      synced_reg <= live;
      q_reg      <= ~cur_q;
      if (cur_q) ch_reg <= (cur_ch >= last_ch) ? 4'h0 : cur_ch + 4'h1;
      else ch_reg <= cur_ch;
      if (!cur_q) i_hold_reg <= word;
      ferr_reg <= misplace | (ferr_reg & ~ferr_clr);
    end
  end

  // gain and pilot on a completed pair
  wire [15:0] cur_gain  = (int'(cur_ch) < NCH) ? gain_reg[cur_ch] : bbf_pkg::GAIN_RST;
  wire [17:0] gi        = bbf_pkg::bbf_scale(i_hold_reg, cur_gain);
  wire [17:0] gq        = bbf_pkg::bbf_scale(word, cur_gain);
  wire        pair_done = live & cur_q & ~bypass_reg;
  wire        pilot_add = pair_done & pilot_en_reg & (cur_ch == pch_reg);
  wire [19:0] pg_ext    = {{4{pgain_reg[15]}}, pgain_reg};
  wire [19:0] pilot_off = pilot_add ? (lfsr_reg[0] ? pg_ext : 20'h0_0000 - pg_ext) : 20'h0_0000;

  // pilot chip sequence advances once per pilot pair; limitation: pseudo random, not a coded channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lfsr_reg <= bbf_pkg::LFSR_RST;
    else if (pilot_add) lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[14] ^ lfsr_reg[12] ^ lfsr_reg[3]};
  end

  // output registers toward upconverter and peak reduction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duc_valid <= 1'b0;
      duc_ch    <= 4'h0;
      duc_i     <= 18'h0_0000;
      duc_q     <= 18'h0_0000;
      prs_valid <= 1'b0;
      prs_iq    <= 1'b0;
      prs_data  <= 18'h0_0000;
    end else begin
      duc_valid <= pair_done;
      if (pair_done) begin
        duc_ch <= cur_ch;
        duc_i  <= bbf_pkg::bbf_add(gi, pilot_off);
        duc_q  <= bbf_pkg::bbf_add(gq, pilot_off);
      end
      prs_valid <= live & bypass_reg;
      prs_iq    <= cur_q;
      prs_data  <= word;
    end
  end

  // power of the registered pair; squares are non-negative so unsigned sum is safe
  wire signed [35:0] sq_i = $signed(duc_i) * $signed(duc_i);
  wire signed [35:0] sq_q = $signed(duc_q) * $signed(duc_q);
  wire [36:0] pwr   = {1'b0, sq_i} + {1'b0, sq_q};
  wire        start = meas_state == bbf_pkg::MEAS_IDLE && run_reg;
  wire        accum = meas_state == bbf_pkg::MEAS_ACC && duc_valid;

  assign mem_bus.rd_addr = reg_idx;
  assign mem_bus.wr_en   = meas_state == bbf_pkg::MEAS_COPY;
  assign mem_bus.wr_addr = walk_reg;
  assign mem_bus.wr_data = acc_reg[walk_reg][bbf_pkg::RES_LSB +: bbf_pkg::RES_W];

  // meter sequencer: clear on start, sum while running, latch all on stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_state <= bbf_pkg::MEAS_IDLE;
      walk_reg   <= 4'h0;
      done_reg   <= 1'b0;
    end else begin
      unique case (meas_state)
        bbf_pkg::MEAS_IDLE: if (run_reg) begin
          meas_state <= bbf_pkg::MEAS_ACC;
          done_reg   <= 1'b0;
        end
        bbf_pkg::MEAS_ACC: if (!run_reg) begin
          meas_state <= bbf_pkg::MEAS_COPY;
          walk_reg   <= 4'h0;
        end
        bbf_pkg::MEAS_COPY: if (walk_reg == LAST_CH) begin
          meas_state <= bbf_pkg::MEAS_IDLE;
          done_reg   <= 1'b1;
        end else begin
          walk_reg <= walk_reg + 4'h1;
        end
        default: meas_state <= bbf_pkg::MEAS_IDLE;
      endcase
    end
  end

  // accumulators, all cleared together at the start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NCH; k++) acc_reg[k] <= 48'h0000_0000_0000;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (start) acc_reg[k] <= 48'h0000_0000_0000;
        else if (accum && int'(duc_ch) == k) acc_reg[k] <= acc_reg[k] + {11'h000, pwr};
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bypass_route: assert property (bypass_reg && live |=> prs_valid && !duc_valid)
    else $error("bypass word not routed to peak reduction");
  a_sample_split: assert property (prs_valid |-> prs_data == $past(word))
    else $error("bypass word not built from bus and pins");
  a_frame_align: assert property (bb_frame_marker |=> q_reg && ch_reg == 4'h0)
    else $error("marker did not align counters");
  a_first_pair: assert property ((bb_frame_marker && !bypass_reg) ##1 (!bb_frame_marker && !bypass_reg)
                                 |=> duc_valid && duc_ch == 4'h0)
    else $error("first pair after marker not on channel zero");
  a_chan_range: assert property (duc_valid |-> int'(duc_ch) < NCH && duc_ch <= $past(last_ch, 1))
    else $error("channel beyond carrier count");
  a_unity_gain: assert property (pair_done && cur_gain == bbf_pkg::GAIN_RST && !pilot_add |=> duc_q == $past(word))
    else $error("unity gain changed the sample");
  a_pilot_step: assert property (pilot_add |=> lfsr_reg != $past(lfsr_reg))
    else $error("pilot sequence did not advance");
  a_power_sum: assert property (accum && !start |=> acc_reg[$past(duc_ch)] == $past(acc_reg[duc_ch]) + $past(pwr))
    else $error("power not accumulated");
  a_meas_clear: assert property (start |=> meas_state == bbf_pkg::MEAS_ACC && acc_reg[0] == 48'h0000_0000_0000)
    else $error("meters not cleared together");
  a_copy_done: assert property (meas_state == bbf_pkg::MEAS_ACC && !run_reg |-> ##[1:COPY_MAX] done_reg)
    else $error("results not latched after stop");

  c_bypass: cover property (prs_valid && prs_iq);
  c_pilot: cover property (pilot_add ##1 duc_valid);
  c_done: cover property ($rose(done_reg));
  c_ferr: cover property ($rose(ferr_reg));
endmodule : bbf_front_end

/* File: verification/bbf_bb_source.sv */
// baseband processor model: streams interleaved i and q words with a frame marker
`timescale 1ns/1ps
module bbf_bb_source (
  input  wire logic        clk,                 // sample clock
  input  wire logic        presetn,             // async reset, active low
  input  wire logic        run,                 // stream enable
  input  wire logic [3:0]  last_ch,             // last carrier sent
  input  wire logic        tag,                 // add a carrier tag to each word
  input  wire logic [17:0] i_val,               // in-phase value for every carrier
  input  wire logic [17:0] q_val,               // quadrature value for every carrier
  output logic      [15:0] bb_sample_bus,       // upper sample bits
  output logic      [1:0]  multi_function_pins, // lowest two sample bits
  output logic             bb_frame_marker      // first word of a frame
);
  logic [3:0]  ch_reg;                          // carrier about to be sent
  logic        q_reg;                           // next word is q
  logic [17:0] fi_reg;                          // in-phase value of this frame
  logic [17:0] fq_reg;                          // quadrature value of this frame
  // i and q values are latched at frame start so a frame never mixes two value settings; tag is applied live
  wire  logic        start = run && ch_reg == 4'h0 && !q_reg;
  wire  logic        busy  = start || ch_reg != 4'h0 || q_reg;
  wire  logic [17:0] ofs   = tag ? {12'h000, ch_reg, 2'b11} : 18'h0_0000;
  wire  logic [17:0] cur_i = start ? i_val : fi_reg;
  wire  logic [17:0] cur_q = start ? q_val : fq_reg;
  wire  logic [17:0] word  = q_reg ? cur_q + ofs : cur_i + ofs;

  // one word per edge; a begun frame is always sent whole
  always_ff @(posedge clk or negedge presetn) begin
    if (!presetn) begin
      {bb_sample_bus, multi_function_pins} <= 18'h0_0000;
      bb_frame_marker <= 1'b0;
      ch_reg <= 4'h0;
      q_reg <= 1'b0;
      fi_reg <= 18'h0_0000;
      fq_reg <= 18'h0_0000;
    end else if (busy) begin
      {bb_sample_bus, multi_function_pins} <= word;
      bb_frame_marker <= start;
      if (start) begin
        fi_reg <= i_val;
        fq_reg <= q_val;
      end
      q_reg <= !q_reg;
      if (q_reg) ch_reg <= (ch_reg == last_ch) ? 4'h0 : ch_reg + 4'h1;
    end else begin
      // idle bus: inverse of the last word, never a stale copy
      {bb_sample_bus, multi_function_pins} <= ~{bb_sample_bus, multi_function_pins};
      bb_frame_marker <= 1'b0;
    end
  end
endmodule : bbf_bb_source

/* File: verification/test_baseband_iq_input_front_end.sv */
// self-checking bench of the baseband input front end fed by the source model
`timescale 1ns/1ps
module test_baseband_iq_input_front_end;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr; // clock, reset, apb
  logic [7:0]  paddr;                           // apb address
  logic [31:0] pwdata, prdata;                  // apb data
  logic [15:0] bus;                             // sample bus
  logic [1:0]  pins;                            // low sample bits
  logic        mark, duc_valid, prs_valid, prs_iq; // marker and output strobes
  logic [3:0]  duc_ch;                          // output carrier
  logic [17:0] duc_i, duc_q, prs_data;          // output samples
  logic        src_run, tag;                    // source controls
  logic [17:0] i_val, q_val;                    // source values
  int          n_errors, num_checks;            // tallies

  bbf_front_end #(.NCH(12)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bb_sample_bus(bus), .multi_function_pins(pins), .bb_frame_marker(mark), .duc_valid(duc_valid),
    .duc_ch(duc_ch), .duc_i(duc_i), .duc_q(duc_q), .prs_valid(prs_valid), .prs_iq(prs_iq), .prs_data(prs_data));
  bbf_bb_source i_src (.clk(pclk), .presetn(presetn), .run(src_run), .last_ch(4'hB), .tag(tag),
    .i_val(i_val), .q_val(q_val), .bb_sample_bus(bus), .multi_function_pins(pins), .bb_frame_marker(mark));

  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // compare and tally
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; waits on pready, bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // wait for the next output pair of carrier c
  task automatic get_pair(input logic [3:0] c, output logic [17:0] i, output logic [17:0] q);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!(duc_valid === 1'b1 && duc_ch === c) && k < 100);
    if (!(duc_valid === 1'b1 && duc_ch === c)) n_errors++;
    i = duc_i;
    q = duc_q;
  endtask : get_pair

  // let n frame markers pass
  task automatic wait_marks(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 1000) begin
      @(posedge pclk);
      k++;
      if (mark === 1'b1) n--;
    end
    if (n > 0) n_errors++;
  endtask : wait_marks

  // register defaults and an unmapped address
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    xfer(1'b0, bbf_pkg::OFS_CTRL, 32'h0000_0000, r, e);
    check(r, 32'h0000_00B0);
    xfer(1'b0, bbf_pkg::OFS_GAIN_BASE + 8'h2C, 32'h0000_0000, r, e);
    check(r, 32'h0000_4000);
    xfer(1'b0, 8'h3C, 32'h0000_0000, r, e);
    check({31'h0, e}, 32'h0000_0001);
    $display("reset test done");
  endtask : t_reset

  // every carrier reaches its own output; then per-carrier gain
  task automatic t_route();
    logic [17:0] i, q;
    logic [31:0] r;
    logic        e;
    tag <= 1'b1;
    i_val <= 18'h0_1000;
    q_val <= 18'h0_2000;
    src_run <= 1'b1;
    for (int c = 0; c < 12; c++) begin
      get_pair(c[3:0], i, q);
      check({14'h0, i}, {14'h0, 18'h0_1000 + {12'h000, c[3:0], 2'b11}});
      check({14'h0, q}, {14'h0, 18'h0_2000 + {12'h000, c[3:0], 2'b11}});
    end
    xfer(1'b1, bbf_pkg::OFS_GAIN_BASE + 8'h0C, 32'h0000_2000, r, e);
    xfer(1'b1, bbf_pkg::OFS_GAIN_BASE + 8'h14, 32'h0000_0000, r, e);
    get_pair(4'h3, i, q);
    get_pair(4'h3, i, q);
    check({14'h0, i}, 32'h0000_0807);
    check({14'h0, q}, 32'h0000_1007);
    $display("route test done");
  endtask : t_route

  // four frames of 256 measured; results held after stop
  task automatic t_power();
    logic [31:0] r;
    logic        e;
    tag <= 1'b0;
    i_val <= 18'h0_0000;
    q_val <= 18'h0_0000;
    wait_marks(2);
    xfer(1'b1, bbf_pkg::OFS_CTRL, 32'h0000_00B4, r, e);
    wait_marks(1);
    i_val <= 18'h0_0100;
    q_val <= 18'h0_0100;
    wait_marks(4);
    i_val <= 18'h0_0000;
    q_val <= 18'h0_0000;
    xfer(1'b0, bbf_pkg::OFS_STATUS, 32'h0000_0000, r, e);
    check(r, 32'h0000_0002);
    wait_marks(2);
    xfer(1'b1, bbf_pkg::OFS_CTRL, 32'h0000_00B0, r, e);
    repeat (16) @(posedge pclk);
    xfer(1'b0, bbf_pkg::OFS_STATUS, 32'h0000_0000, r, e);
    check(r, 32'h0000_0001);
    xfer(1'b0, bbf_pkg::OFS_POWER_BASE, 32'h0000_0000, r, e);
    check(r, 32'h0000_0008);
    xfer(1'b0, bbf_pkg::OFS_POWER_BASE + 8'h0C, 32'h0000_0000, r, e);
    check(r, 32'h0000_0002);
    xfer(1'b0, bbf_pkg::OFS_POWER_BASE + 8'h14, 32'h0000_0000, r, e);
    check(r, 32'h0000_0000);
    xfer(1'b1, bbf_pkg::OFS_POWER_BASE, 32'hFFFF_FFFF, r, e);
    wait_marks(1);
    xfer(1'b0, bbf_pkg::OFS_POWER_BASE, 32'h0000_0000, r, e);
    check(r, 32'h0000_0008);
    $display("power test done");
  endtask : t_power

  // bypass: raw words out each cycle, no channel pairs
  task automatic t_bypass();
    logic [31:0] r;
    logic        e;
    int          nd, np;
    xfer(1'b1, bbf_pkg::OFS_CTRL, 32'h0000_00B1, r, e);
    i_val <= 18'h0_1234;
    q_val <= 18'h3_0F0F;
    wait_marks(2);
    nd = 0;
    np = 0;
    repeat (24) begin
      @(posedge pclk);
      if (duc_valid === 1'b1) nd++;
      if (prs_valid === 1'b1) np++;
      if (prs_valid === 1'b1) check({14'h0, prs_data}, {14'h0, prs_iq ? q_val : i_val});
    end
    check(32'(nd), 32'h0000_0000);
    check(32'(np), 32'h0000_0018);
    $display("bypass test done");
  endtask : t_bypass

  // a carrier count shorter than the source puts markers out of place; write one clears the flag
  // done in bypass so no channel pair runs past the shortened count
  task automatic t_marker();
    logic [31:0] r;
    logic        e;
    xfer(1'b1, bbf_pkg::OFS_CTRL, 32'h0000_0041, r, e);
    wait_marks(2);
    xfer(1'b1, bbf_pkg::OFS_CTRL, 32'h0000_00B1, r, e);
    xfer(1'b0, bbf_pkg::OFS_STATUS, 32'h0000_0000, r, e);
    check(r, 32'h0000_0005);
    wait_marks(1);
    xfer(1'b1, bbf_pkg::OFS_STATUS, 32'h0000_0004, r, e);
    xfer(1'b0, bbf_pkg::OFS_STATUS, 32'h0000_0000, r, e);
    check(r, 32'h0000_0001);
    $display("marker test done");
  endtask : t_marker

  // pilot of +/-0x100 lands on carrier 0 only
  task automatic t_pilot();
    logic [17:0] i, q;
    logic [31:0] r;
    logic        e;
    xfer(1'b1, bbf_pkg::OFS_PILOT_GAIN, 32'h0000_0100, r, e);
    xfer(1'b1, bbf_pkg::OFS_CTRL, 32'h0000_00B2, r, e);
    i_val <= 18'h0_0000;
    q_val <= 18'h0_0000;
    wait_marks(2);
    get_pair(4'h0, i, q);
    check({31'h0, i === 18'h0_0100 || i === 18'h3_FF00}, 32'h0000_0001);
    get_pair(4'h1, i, q);
    check({14'h0, i}, 32'h0000_0000);
    $display("pilot test done");
  endtask : t_pilot

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {src_run, tag, i_val, q_val} = '0;
    n_errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_route();
    t_power();
    t_bypass();
    t_marker();
    t_pilot();
    wrap_up();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(25 * 20000);
    n_errors++;
    wrap_up();
  end
endmodule : test_baseband_iq_input_front_end
